// ---- core/edml_pkg.sv ----
// Shared constants and types of the diagnostic and mode logic
package edml_pkg;
    // Widths
    localparam int DATA_W     = 32;
    localparam int CB_W       = 8;
    localparam int TALLY_W    = 4;
    localparam int FIFO_DEPTH = 16;
    // Mode codes on the three mode inputs
    localparam logic [2:0] MODE_ERR_DATA = 3'h0;
    localparam logic [2:0] MODE_INJECT   = 3'h4;
    localparam logic [1:0] MODE_NORMAL   = 2'h3;
    localparam logic [1:0] MODE_DETECT   = 2'h2;
    localparam logic [1:0] MODE_DIAG     = 2'h1;
    // Diagnostic word field positions
    localparam int CBI_LSB   = 0;
    localparam int PARTIAL_CHECKBIT_INPUT_BUS_LSB  = 8;
    localparam int SYN_LSB   = 16;
    localparam int TALLY_LSB = 24;
    localparam int TEST_LSB  = 28;
    localparam int KIND_LSB  = 30;
    // Reset and limit values
    localparam logic [31:0] WORD_RST  = 32'h0000_0000;
    localparam logic [7:0]  SYN_RST   = 8'h00;
    localparam logic [3:0]  TALLY_RST = 4'h0;
    localparam logic [3:0]  TALLY_MAX = 4'hf;
    localparam logic [1:0]  KIND_NONE   = 2'h0;
    localparam logic [1:0]  KIND_SINGLE = 2'h2;
    localparam logic [1:0]  KIND_MULTI  = 2'h1;
    localparam logic [1:0]  FACTORY_TEST_VAL = 2'h0;
    // Cascade position of this slice
    typedef enum logic [1:0] {
        SLICE_SINGLE32 = 2'h0,
        SLICE_GEN64    = 2'h1,
        SLICE_LOWER    = 2'h2,
        SLICE_UPPER    = 2'h3
    } edml_slice_t;
endpackage

// ---- core/edml_cap_if.sv ----
// Link between the top and the capture register block
`timescale 1ns/1ns
interface edml_cap_if;
    logic        capture_pulse;
    logic        clear_n;
    logic        err_active;
    logic        multi_err;
    logic [7:0]  syndrome;
    logic [31:0] mem_word;
    logic [31:0] cap_word;
    logic [7:0]  cap_syn;
    logic [3:0]  tally;
    logic [1:0]  kind;
    modport core (
        output capture_pulse, clear_n, err_active, multi_err,
        output syndrome, mem_word,
        input  cap_word, cap_syn, tally, kind
    );
    modport cap (
        input  capture_pulse, clear_n, err_active, multi_err,
        input  syndrome, mem_word,
        output cap_word, cap_syn, tally, kind
    );
endinterface

// ---- core/edml_fifo.sv ----
// Flip-flop FIFO for read words, corrected except in detect-only mode
`timescale 1ns/1ns
module edml_fifo #(
    parameter int W     = 32,
    parameter int DEPTH = 16
) (
    input  wire logic         core_clk,
    input  wire logic         rst,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wr;
        logic [AW-1:0]           rd;
        logic [AW:0]             cnt;
    } edml_fifo_t;
    edml_fifo_t s_reg;
    edml_fifo_t s_next;
    logic       push;
    logic       pop;

    // Honest flags straight from the fill count
    assign in_ready  = (s_reg.cnt != (AW+1)'(DEPTH));
    assign out_valid = (s_reg.cnt != '0);
    assign out_data  = s_reg.mem[s_reg.rd];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // Pointer and count update
    always_comb begin
        s_next = s_reg;
        if (push) begin
            s_next.mem[s_reg.wr] = in_data;
            s_next.wr = s_reg.wr + 1'b1;
        end
        if (pop) begin
            s_next.rd = s_reg.rd + 1'b1;
        end
        if (push && !pop) begin
            s_next.cnt = s_reg.cnt + 1'b1;
        end else if (pop && !push) begin
            s_next.cnt = s_reg.cnt - 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end
endmodule

// ---- core/edml_capture.sv ----
// First-error capture registers and saturating error tally
`timescale 1ns/1ns
module edml_capture (
    input  wire logic core_clk,
    input  wire logic rst,
    edml_cap_if.cap   cif
);
    typedef struct packed {
        logic [31:0] word;
        logic [7:0]  syn;
        logic [3:0]  tally;
        logic [1:0]  kind;
    } edml_cap_t;
    edml_cap_t s_reg;
    edml_cap_t s_next;

    assign cif.cap_word = s_reg.word;
    assign cif.cap_syn  = s_reg.syn;
    assign cif.tally    = s_reg.tally;
    assign cif.kind     = s_reg.kind;

    // Clear first, then a capture edge on top of it, so no error is lost
    always_comb begin
        s_next = s_reg;
        if (!cif.clear_n) begin
            s_next.word  = edml_pkg::WORD_RST;
            s_next.syn   = edml_pkg::SYN_RST;
            s_next.tally = edml_pkg::TALLY_RST;
            s_next.kind  = edml_pkg::KIND_NONE;
        end
        if (cif.capture_pulse && cif.err_active) begin
            if (s_next.tally == edml_pkg::TALLY_RST) begin
                s_next.word = cif.mem_word;
                s_next.syn  = cif.syndrome;
                s_next.kind = cif.multi_err ?
                    edml_pkg::KIND_MULTI : edml_pkg::KIND_SINGLE;
            end
            // Holds at fifteen instead of wrapping
            if (s_next.tally != edml_pkg::TALLY_MAX) begin
                s_next.tally = s_next.tally + 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_reg <= '{edml_pkg::WORD_RST, edml_pkg::SYN_RST,
                       edml_pkg::TALLY_RST, edml_pkg::KIND_NONE};
        end else begin
            s_reg <= s_next;
        end
    end
endmodule

// ---- core/edml_top.sv ----
// Diagnostic and mode selection logic of the 32-bit EDC unit
// How it works
// - Mode x11 runs ordinary detect-and-correct operation.
// - Mode x10 detects errors but passes read data uncorrected.
// - Mode 000 drives the captured error word onto the system bus.
// - Capture edge, error low, tally zero: load the latched memory word.
// - Clear low zeroes captured word, captured syndrome and tally.
// - A cleared captured word serves as an all-zero data source.
// - Mode x01 shows diagnostic registers, partial checkbits and checkbits.
// - Diagnostic readback: checkbit latch bits 0-7, partial checkbits 8-15.
// - Syndrome captured like the word, read back on bits 16-23.
// - Four-bit tally counts capture edges with error, holds at 15.
// - Bits 28-29 carry factory test bits; the host ignores them.
// - Error-kind register keeps first error type, read on bits 30-31.
// - Mode 100 loads system latch bits 0-7 as checkbits on latch strobe.
// - Mode 100 otherwise behaves exactly like normal mode.
// - Slice code selects standalone, generate-only, lower or upper role.
// - Active-low error flag follows live detection, never latched.
`timescale 1ns/1ns
module edml_top (
    input  wire logic        core_clk,
    input  wire logic        rst,
    // Pins, all asynchronous to core_clk
    input  wire logic [2:0]  mode_pins,
    input  wire logic [1:0]  slice_position_code,
    input  wire logic        clear_n,
    input  wire logic        syndrome_capture_clock,
    input  wire logic        memory_latch_enable,
    input  wire logic        system_latch_enable,
    input  wire logic        system_output_enable_n,
    input  wire logic [31:0] memory_data_bus_in,
    input  wire logic [7:0]  checkbit_input_bus,
    input  wire logic [7:0]  partial_checkbit_input_bus,
    input  wire logic [31:0] system_data_bus_in,
    // Correction network, same clock
    input  wire logic [7:0]  gen_syndrome,
    input  wire logic [31:0] corrected_word,
    input  wire logic        multi_err,
    output logic [31:0]      mem_latch_word,
    output logic [7:0]       checkbit_latch,
    // System side
    output logic [31:0]      system_data_bus_out,
    output logic             system_data_bus_oe,
    output logic             read_valid,
    input  wire logic        read_ready,
    output logic             mem_ready,
    output logic             err_n,
    output logic [1:0]       slice_role
);
    typedef struct packed {
        logic [2:0]  mode_s1;
        logic [2:0]  mode_s2;
        logic [1:0]  slice_s1;
        logic [1:0]  slice_s2;
        logic        clr_s1;
        logic        clr_s2;
        logic        cclk_s1;
        logic        cclk_s2;
        logic        cclk_d;
        logic        mle_s1;
        logic        mle_s2;
        logic        mle_d;
        logic        sle_s1;
        logic        sle_s2;
        logic        sle_d;
        logic        soe_s1;
        logic        soe_s2;
        logic [31:0] md_s1;
        logic [31:0] md_s2;
        logic [7:0]  cbi_s1;
        logic [7:0]  cbi_s2;
        logic [7:0]  partial_checkbit_input_bus_s1;
        logic [7:0]  partial_checkbit_input_bus_s2;
        logic [31:0] sd_s1;
        logic [31:0] sd_s2;
        logic [31:0] sd_latch;
        logic [31:0] md_latch;
        logic [7:0]  cb_latch;
        logic        pending;
        logic [31:0] sd_out;
        logic        sd_oe;
    } edml_top_t;

    edml_top_t   s_reg;
    edml_top_t   s_next;
    edml_cap_if  cif ();

    logic        cap_pulse;
    logic        mle_pulse;
    logic        sle_pulse;
    logic        mode_err_data;
    logic        mode_diag;
    logic        mode_detect;
    logic        mode_inject;
    logic        detect_on;
    logic        err_live;
    logic        fifo_in_ready;
    logic        fifo_out_valid;
    logic        fifo_out_ready;
    logic [31:0] fifo_out_data;
    logic [31:0] push_word;
    logic [31:0] diag_word;

    // Edges are taken from the second sync stage only
    assign cap_pulse = s_reg.cclk_s2 & ~s_reg.cclk_d;
    assign mle_pulse = s_reg.mle_s2 & ~s_reg.mle_d;
    assign sle_pulse = s_reg.sle_s2 & ~s_reg.sle_d;

    // Mode decode; the top bit is ignored where it is a don't care
    assign mode_err_data = (s_reg.mode_s2 == edml_pkg::MODE_ERR_DATA);
    assign mode_inject   = (s_reg.mode_s2 == edml_pkg::MODE_INJECT);
    assign mode_diag     = (s_reg.mode_s2[1:0] == edml_pkg::MODE_DIAG);
    assign mode_detect   = (s_reg.mode_s2[1:0] == edml_pkg::MODE_DETECT);

    // Detection runs in normal, detect-only and injection modes
    assign detect_on =
        (s_reg.mode_s2[1:0] == edml_pkg::MODE_NORMAL) |
        mode_detect |
        mode_inject;

    // A generate-only slice checks nothing, so it never flags
    assign err_live = detect_on &
        (s_reg.slice_s2 != edml_pkg::SLICE_GEN64) &
        (gen_syndrome != edml_pkg::SYN_RST);

    // Flag is plain logic: not latched, not gated by any enable
    assign err_n = ~err_live;

    // Detect-only passes the latched word untouched
    assign push_word = mode_detect ? s_reg.md_latch
                                   : corrected_word;

    // Diagnostic composite, field by field
    always_comb begin
        diag_word = edml_pkg::WORD_RST;
        diag_word[edml_pkg::CBI_LSB +: 8]  = s_reg.cb_latch;
        diag_word[edml_pkg::PARTIAL_CHECKBIT_INPUT_BUS_LSB +: 8] = s_reg.partial_checkbit_input_bus_s2;
        diag_word[edml_pkg::SYN_LSB +: 8]  = cif.cap_syn;
        diag_word[edml_pkg::TALLY_LSB +: 4] = cif.tally;
        diag_word[edml_pkg::TEST_LSB +: 2] =
            edml_pkg::FACTORY_TEST_VAL;
        diag_word[edml_pkg::KIND_LSB +: 2] = cif.kind;
    end

    // Hand-off to the capture registers
    assign cif.capture_pulse = cap_pulse;
    assign cif.clear_n       = s_reg.clr_s2;
    assign cif.err_active    = err_live;
    assign cif.multi_err     = multi_err;
    assign cif.syndrome      = gen_syndrome;
    assign cif.mem_word      = s_reg.md_latch;

    edml_capture u_capture (
        .core_clk (core_clk),
        .rst      (rst),
        .cif      (cif)
    );

    // Read words queue here; a stalled reader fills it and
    // then holds off further memory latch strobes
    edml_fifo #(
        .W     (edml_pkg::DATA_W),
        .DEPTH (edml_pkg::FIFO_DEPTH)
    ) u_fifo (
        .core_clk  (core_clk),
        .rst       (rst),
        .in_valid  (s_reg.pending),
        .in_ready  (fifo_in_ready),
        .in_data   (push_word),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    // Readback modes own the bus, so the queue only drains otherwise
    assign fifo_out_ready = read_ready & ~mode_err_data & ~mode_diag;
    assign read_valid     = fifo_out_valid & ~mode_err_data & ~mode_diag;
    assign mem_ready      = ~s_reg.pending;

    assign mem_latch_word      = s_reg.md_latch;
    assign checkbit_latch      = s_reg.cb_latch;
    assign system_data_bus_out = s_reg.sd_out;
    assign system_data_bus_oe  = s_reg.sd_oe;
    assign slice_role          = s_reg.slice_s2;

    // Next state of all synchronisers, latches and outputs
    always_comb begin
        s_next = s_reg;
        // Two-stage synchronisers for every pin
        s_next.mode_s1  = mode_pins;
        s_next.mode_s2  = s_reg.mode_s1;
        s_next.slice_s1 = slice_position_code;
        s_next.slice_s2 = s_reg.slice_s1;
        s_next.clr_s1   = clear_n;
        s_next.clr_s2   = s_reg.clr_s1;
        s_next.cclk_s1  = syndrome_capture_clock;
        s_next.cclk_s2  = s_reg.cclk_s1;
        s_next.cclk_d   = s_reg.cclk_s2;
        s_next.mle_s1   = memory_latch_enable;
        s_next.mle_s2   = s_reg.mle_s1;
        s_next.mle_d    = s_reg.mle_s2;
        s_next.sle_s1   = system_latch_enable;
        s_next.sle_s2   = s_reg.sle_s1;
        s_next.sle_d    = s_reg.sle_s2;
        s_next.soe_s1   = system_output_enable_n;
        s_next.soe_s2   = s_reg.soe_s1;
        s_next.md_s1    = memory_data_bus_in;
        s_next.md_s2    = s_reg.md_s1;
        s_next.cbi_s1   = checkbit_input_bus;
        s_next.cbi_s2   = s_reg.cbi_s1;
        s_next.partial_checkbit_input_bus_s1  = partial_checkbit_input_bus;
        s_next.partial_checkbit_input_bus_s2  = s_reg.partial_checkbit_input_bus_s1;
        s_next.sd_s1    = system_data_bus_in;
        s_next.sd_s2    = s_reg.sd_s1;

        // System input latch
        if (sle_pulse) begin
            s_next.sd_latch = s_reg.sd_s2;
        end

        // Queue takes the finished word one cycle after the latch
        if (s_reg.pending && fifo_in_ready) begin
            s_next.pending = 1'b0;
        end

        // A strobe while a word still waits is dropped, not queued
        if (mle_pulse && !s_reg.pending) begin
            s_next.md_latch = s_reg.md_s2;
            s_next.pending  = 1'b1;
            if (mode_inject) begin
                s_next.cb_latch = s_reg.sd_latch[7:0];
            end else begin
                s_next.cb_latch = s_reg.cbi_s2;
            end
        end

        // Output word follows the mode; host supplies the enable
        case (1'b1)
            mode_err_data: s_next.sd_out = cif.cap_word;
            mode_diag:     s_next.sd_out = diag_word;
            default:       s_next.sd_out = fifo_out_data;
        endcase
        s_next.sd_oe = ~s_reg.soe_s2;
    end

    // Sync stages reset to the idle pin levels
    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_reg        <= '0;
            s_reg.clr_s1 <= 1'b1;
            s_reg.clr_s2 <= 1'b1;
            s_reg.soe_s1 <= 1'b1;
            s_reg.soe_s2 <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end
endmodule

// ---- tb/edml_net_model.sv ----
// Correction network model for the bench
`timescale 1ns/1ns
module edml_net_model (
    input  wire logic [31:0] word,
    input  wire logic [7:0]  cbits,
    output logic [7:0]       syn,
    output logic [31:0]      fixed,
    output logic             multi
);
    // Byte-fold checkbits keep it tiny; not a real Hamming code
    always_comb begin
        syn = cbits ^ word[7:0] ^ word[15:8] ^ word[23:16] ^ word[31:24];
        multi = $countones(syn) > 1;
        fixed = multi ? word : word ^ {24'h0, syn};
    end
endmodule

// ---- tb/edml_chk.sv ----
// Port assertions for the diagnostic and mode logic
`timescale 1ns/1ns
module edml_chk (
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic [2:0]  mode_pins,
    input wire logic [1:0]  slice_position_code,
    input wire logic        clear_n,
    input wire logic        syndrome_capture_clock,
    input wire logic [7:0]  partial_checkbit_input_bus,
    input wire logic [7:0]  gen_syndrome,
    input wire logic [7:0]  checkbit_latch,
    input wire logic [31:0] system_data_bus_out,
    input wire logic        err_n,
    input wire logic [1:0]  slice_role
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // Pins need two sync edges and a register stage to show
    sequence s_diag;
        (!rst && mode_pins[1:0] == 2'h1
            && $stable(partial_checkbit_input_bus))[*5];
    endsequence
    sequence s_normal;
        (!rst && mode_pins[1:0] == 2'h3
            && slice_position_code == 2'h0)[*5];
    endsequence
    sequence s_cleared;
        (!rst && mode_pins == 3'h0 && !clear_n
            && !syndrome_capture_clock)[*6];
    endsequence
    a_diag_checkbits: assert property (s_diag |->
        system_data_bus_out[7:0] == $past(checkbit_latch))
        else $error("diag checkbits wrong");
    a_diag_partial: assert property (s_diag |->
        system_data_bus_out[15:8] == partial_checkbit_input_bus)
        else $error("diag partial checkbits wrong");
    a_test_bits: assert property (s_diag |->
        system_data_bus_out[29:28] == 2'h0)
        else $error("factory bits not driven");
    a_errword_clear: assert property (s_cleared |->
        system_data_bus_out == 32'h0)
        else $error("cleared word not zero");
    a_err_quiet: assert property (
        gen_syndrome == 8'h00 |-> err_n)
        else $error("error flag without syndrome");
    a_err_live: assert property (
        s_normal ##0 gen_syndrome != 8'h00 |-> !err_n)
        else $error("error flag missing");
    a_gen_only: assert property (
        (!rst && slice_position_code == 2'h1)[*4] |-> err_n)
        else $error("generate-only slice flags error");
    a_slice_role: assert property (
        (!rst && $stable(slice_position_code))[*5]
        |-> slice_role == slice_position_code)
        else $error("slice role wrong");
endmodule
bind edml_top edml_chk chk_u (
    .core_clk, .rst, .mode_pins, .slice_position_code, .clear_n,
    .syndrome_capture_clock, .partial_checkbit_input_bus, .gen_syndrome,
    .checkbit_latch, .system_data_bus_out, .err_n, .slice_role
);

// ---- tb/edc_diagnostic_mode_logic_test.sv ----
// Self-checking bench for the diagnostic and mode logic
`timescale 1ns/1ns
module edc_diagnostic_mode_logic_test;
    logic        core_clk, rst, clear_n, syndrome_capture_clock;
    logic        memory_latch_enable, system_latch_enable, read_ready;
    logic        system_output_enable_n, multi_err, system_data_bus_oe;
    logic        read_valid, mem_ready, err_n;
    logic [2:0]  mode_pins;
    logic [1:0]  slice_position_code, slice_role;
    logic [7:0]  checkbit_input_bus, partial_checkbit_input_bus;
    logic [7:0]  gen_syndrome, checkbit_latch;
    logic [31:0] memory_data_bus_in, system_data_bus_in, corrected_word;
    logic [31:0] mem_latch_word, system_data_bus_out, md, md2;
    logic [31:0] expq[$];
    integer      seed;
    int          errors, n_compared, i;

    edml_top dut_u (
        .core_clk, .rst, .mode_pins, .slice_position_code, .clear_n,
        .syndrome_capture_clock, .memory_latch_enable, .system_latch_enable,
        .system_output_enable_n, .memory_data_bus_in, .checkbit_input_bus,
        .partial_checkbit_input_bus, .system_data_bus_in, .gen_syndrome,
        .corrected_word, .multi_err, .mem_latch_word, .checkbit_latch,
        .system_data_bus_out, .system_data_bus_oe, .read_valid, .read_ready,
        .mem_ready, .err_n, .slice_role
    );
    edml_net_model net_u (
        .word(mem_latch_word), .cbits(checkbit_latch), .syn(gen_syndrome),
        .fixed(corrected_word), .multi(multi_err)
    );

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic check(string what, logic [31:0] seen, logic [31:0] want);
        n_compared++;
        if (seen !== want) begin
            errors++;
            $display("unexpected %s expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic test_done();
        if (errors == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic cyc(int n);
        repeat (n) @(negedge core_clk);
    endtask
    // Edge pins need several cycles high and low to pass the syncs
    task automatic pulse(ref logic p);
        p = 1'b1;
        cyc(3);
        p = 1'b0;
        cyc(3);
    endtask
    task automatic capt(int n);
        cyc(3);
        repeat (n) pulse(syndrome_capture_clock);
    endtask
    function automatic logic [7:0] fold(logic [31:0] w);
        return w[7:0] ^ w[15:8] ^ w[23:16] ^ w[31:24];
    endfunction
    task automatic rd(logic [31:0] w, logic [7:0] cb);
        memory_data_bus_in = w;
        checkbit_input_bus = cb;
        cyc(1);
        pulse(memory_latch_enable);
    endtask
    // Let the output register settle on the head before popping it
    task automatic pop();
        for (int k = 0; k < 40 && read_valid !== 1'b1; k++) cyc(1);
        cyc(2);
        read_ready = 1'b1;
        cyc(1);
        read_ready = 1'b0;
    endtask
    task automatic diag(logic [7:0] cb, logic [7:0] s, logic [3:0] t,
                        logic [1:0] k);
        logic [31:0] want;
        logic [31:0] got;
        mode_pins = 3'h1;
        cyc(6);
        want = {k, 2'h0, t, s, partial_checkbit_input_bus, cb};
        got = system_data_bus_out & 32'hcfffffff;
        check("oe", system_data_bus_oe, 32'h1);
        check("diag", got, want);
    endtask
    task automatic errword(logic [31:0] w);
        mode_pins = 3'h0;
        cyc(6);
        check("error_word", system_data_bus_out, w);
    endtask

    // Popped words are matched against the oldest note
    always @(posedge core_clk) begin
        if (read_valid === 1'b1 && read_ready === 1'b1)
            check("word", system_data_bus_out, expq.pop_front());
    end

    // Watchdog, far beyond the few hundred cycles the run needs
    initial begin
        #200000;
        errors++;
        test_done();
    end

    initial begin
        seed = 32'hcfe2;
        errors = 0;
        n_compared = 0;
        {clear_n, system_output_enable_n} = 2'h3;
        {syndrome_capture_clock, memory_latch_enable} = 2'h0;
        {system_latch_enable, read_ready} = 2'h0;
        {mode_pins, slice_position_code} = 5'h0c;
        {memory_data_bus_in, system_data_bus_in} = 64'h0;
        {checkbit_input_bus, partial_checkbit_input_bus} = 16'h0;
        rst = 1'b1;
        cyc(4);
        rst = 1'b0;
        partial_checkbit_input_bus = $random(seed);
        system_output_enable_n = 1'b0;
        for (i = 0; i < 4; i++) begin
            slice_position_code = i[1:0];
            cyc(5);
            check("slice_role", slice_role, i);
        end
        slice_position_code = 2'h0;
        diag(8'h0, 8'h0, 4'h0, 2'h0);
        // Single-bit error corrected, then captured as first error
        mode_pins = 3'h3;
        md = $random(seed);
        rd(md, fold(md) ^ 8'h01);
        expq.push_back(md ^ 32'h1);
        check("err_n", err_n, 32'h0);
        pop();
        capt(1);
        diag(fold(md) ^ 8'h01, 8'h01, 4'h1, 2'h2);
        errword(md);
        // Multiple-bit error: tally counts, first word and kind stay
        mode_pins = 3'h2;
        md2 = $random(seed);
        rd(md2, fold(md2) ^ 8'h03);
        expq.push_back(md2);
        pop();
        capt(1);
        diag(fold(md2) ^ 8'h03, 8'h01, 4'h2, 2'h2);
        errword(md);
        // Tally saturates at fifteen
        mode_pins = 3'h2;
        capt(14);
        diag(fold(md2) ^ 8'h03, 8'h01, 4'hf, 2'h2);
        // Clear in word-out mode gives an all-zero source
        mode_pins = 3'h0;
        clear_n = 1'b0;
        cyc(9);
        clear_n = 1'b1;
        errword(32'h0);
        diag(fold(md2) ^ 8'h03, 8'h00, 4'h0, 2'h0);
        mode_pins = 3'h2;
        capt(1);
        diag(fold(md2) ^ 8'h03, 8'h03, 4'h1, 2'h1);
        errword(md2);
        // Clean word: the capture edge is ignored
        mode_pins = 3'h3;
        md = $random(seed);
        rd(md, fold(md));
        expq.push_back(md);
        pop();
        capt(1);
        diag(fold(md), 8'h03, 4'h1, 2'h1);
        // Injected checkbits replace memory checkbits
        mode_pins = 3'h4;
        md = $random(seed);
        md2 = $random(seed);
        system_data_bus_in = {md2[31:8], fold(md) ^ 8'h04};
        cyc(1);
        pulse(system_latch_enable);
        rd(md, md2[15:8]);
        check("cb_latch", checkbit_latch, fold(md) ^ 8'h04);
        check("md_latch", mem_latch_word, md);
        expq.push_back(md ^ 32'h4);
        pop();
        // Fill until a strobe is refused, then drain in order
        mode_pins = 3'h3;
        for (i = 0; i < 18; i++) begin
            md = $random(seed);
            rd(md, fold(md) ^ {7'h0, i[0]});
            if (i < 17) expq.push_back(md ^ {31'h0, i[0]});
        end
        check("mem_ready", mem_ready, 32'h0);
        repeat (17) pop();
        check("left", expq.size(), 32'h0);
        test_done();
    end
endmodule
